// File: abd_pkg.sv
// constants for the alu and branch decode slice
package abd_pkg;
    // ------------------------------------------------------------
    // opcode fields
    // ------------------------------------------------------------
    localparam logic [3:0] OP_LIT_HI    = 4'h0;
    localparam logic [3:0] OP_ADD_IMM   = 4'hF;
    localparam logic [3:0] OP_AND_IMM   = 4'hB;
    localparam logic [3:0] OP_ADDREG_HI = 4'h2;
    localparam logic [1:0] OP_ADD_REG   = 2'h1;
    localparam logic [1:0] OP_ADDC_REG  = 2'h0;
    localparam logic [3:0] OP_ANDREG_HI = 4'h1;
    localparam logic [1:0] OP_AND_REG   = 2'h1;
    localparam logic [3:0] OP_BITCLR_HI = 4'h9;
    localparam logic [3:0] OP_BRANCH_HI = 4'hE;
    localparam logic [3:0] BR_NOT_ZERO  = 4'h1;
    localparam logic [3:0] BR_CARRY     = 4'h2;
    localparam logic [3:0] BR_NO_CARRY  = 4'h3;
    localparam logic [3:0] BR_NO_OVFL   = 4'h5;
    localparam logic [3:0] BR_NEGATIVE  = 4'h6;
    localparam logic [3:0] BR_NOT_NEG   = 4'h7;
    // ------------------------------------------------------------
    // status bit positions, reset values, access bank and pc step
    // ------------------------------------------------------------
    localparam int          FLAG_C      = 0;
    localparam int          FLAG_DC     = 1;
    localparam int          FLAG_Z      = 2;
    localparam int          FLAG_OV     = 3;
    localparam int          FLAG_N      = 4;
    localparam logic [4:0]  STATUS_RST  = 5'h00;
    localparam logic [7:0]  WORK_RST    = 8'h00;
    localparam logic [3:0]  BANK_RST    = 4'h0;
    localparam logic [3:0]  ACCESS_BANK = 4'h0;
    localparam logic [20:0] PC_RST      = 21'h000000;
    localparam logic [20:0] PC_STEP     = 21'h000002;
    // ------------------------------------------------------------
    // instruction phases
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        ABD_PH_DECODE  = 4'b0001,
        ABD_PH_READ    = 4'b0010,
        ABD_PH_PROCESS = 4'b0100,
        ABD_PH_WRITE   = 4'b1000
    } abd_phase_t;
endpackage : abd_pkg

// File: abd_core.sv
// alu and conditional branch decode/execute slice
//
// Our own choices: the plain strobed port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
// Function
// - add immediate to working register, flags NOVCDZ
// - add working and file register, flags NOVCDZ
// - add working, carry, file register, flags
// - destination bit: 0 working, 1 file
// - access bit: 0 access bank, 1 bank register
// - and with register or immediate, flags N Z
// - bit clear in file, no flags, one cycle
// - branch target is pc plus 2 plus 2n
// - branch one cycle, two when taken
// - branch on carry set, flags untouched
// - branch on carry clear, flags untouched
// - branch on negative set or clear
// - branch on overflow clear else fall through
// - branch on zero clear else fall through
module abd_core
    import abd_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        resetn,
    input  wire logic [15:0] instr_word,
    input  wire logic        instr_valid,
    input  wire logic [3:0]  bank_select_register,
    input  wire logic [7:0]  file_rdata,
    output logic      [11:0] file_addr,
    output logic             file_we,
    output logic      [7:0]  file_wdata,
    output logic      [7:0]  work_value,
    output logic      [4:0]  status_flags,
    output logic      [20:0] pc_value,
    output logic      [3:0]  phase,
    output logic             instr_accept,
    output logic             flush_busy
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    abd_phase_t  ph_reg,     ph_next;
    logic [15:0] ir_reg,     ir_next;
    logic        live_reg,   live_next;
    logic        flush_reg,  flush_next;
    logic [7:0]  opnd_reg,   opnd_next;
    logic [7:0]  res_reg,    res_next;
    logic [4:0]  stres_reg,  stres_next;
    logic [7:0]  work_reg,   work_next;
    logic [4:0]  stat_reg,   stat_next;
    logic [20:0] pc_reg,     pc_next;
    logic [11:0] addr_reg,   addr_next;
    logic        we_reg,     we_next;
    logic [7:0]  wdata_reg,  wdata_next;

    // ------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------
    function automatic logic [8:0] add9(input logic [7:0] a,
                                        input logic [7:0] b,
                                        input logic       ci);
        add9 = {1'b0, a} + {1'b0, b} + {8'h00, ci};
    endfunction : add9

    // flags for an addition: n ov c dc z in package positions
    function automatic logic [4:0] add_flags(input logic [7:0] a,
                                             input logic [7:0] b,
                                             input logic       ci);
        logic [8:0] s;
        logic [4:0] f;
        logic [4:0] lo;
        s  = add9(a, b, ci);
        lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
        f  = 5'h00;
        f[FLAG_C]  = s[8];
        f[FLAG_DC] = lo[4];
        f[FLAG_Z]  = (s[7:0] == 8'h00);
        f[FLAG_OV] = (a[7] == b[7]) && (s[7] != a[7]);
        f[FLAG_N]  = s[7];
        add_flags  = f;
    endfunction : add_flags

    logic [3:0] hi;
    logic [3:0] sub;
    logic       is_addimm, is_andimm, is_add, is_addc, is_and;
    logic       is_bclr, is_branch, is_regop, br_cond;
    logic [20:0] br_target;

    always_comb begin
        hi        = ir_reg[15:12];
        sub       = ir_reg[11:8];
        is_addimm = (hi == OP_LIT_HI) && (sub == OP_ADD_IMM);
        is_andimm = (hi == OP_LIT_HI) && (sub == OP_AND_IMM);
        is_add    = (hi == OP_ADDREG_HI) && (sub[3:2] == OP_ADD_REG);
        is_addc   = (hi == OP_ADDREG_HI) && (sub[3:2] == OP_ADDC_REG);
        is_and    = (hi == OP_ANDREG_HI) && (sub[3:2] == OP_AND_REG);
        is_bclr   = (hi == OP_BITCLR_HI);
        is_branch = (hi == OP_BRANCH_HI);
        is_regop  = is_add || is_addc || is_and || is_bclr;
        unique case (sub)
            BR_CARRY:    br_cond = stat_reg[FLAG_C];
            BR_NO_CARRY: br_cond = !stat_reg[FLAG_C];
            BR_NEGATIVE: br_cond = stat_reg[FLAG_N];
            BR_NOT_NEG:  br_cond = !stat_reg[FLAG_N];
            BR_NO_OVFL:  br_cond = !stat_reg[FLAG_OV];
            BR_NOT_ZERO: br_cond = !stat_reg[FLAG_Z];
            default:     br_cond = 1'b0;
        endcase
        // pc already points past this word, so target is addr+2+2n
        br_target = pc_reg + {{12{ir_reg[7]}}, ir_reg[7:0], 1'b0};
    end

    // ------------------------------------------------------------
    // phase sequencer and datapath
    // ------------------------------------------------------------
    always_comb begin
        ph_next    = ph_reg;
        ir_next    = ir_reg;
        live_next  = live_reg;
        flush_next = flush_reg;
        opnd_next  = opnd_reg;
        res_next   = res_reg;
        stres_next = stres_reg;
        work_next  = work_reg;
        stat_next  = stat_reg;
        pc_next    = pc_reg;
        addr_next  = addr_reg;
        we_next    = 1'b0;
        wdata_next = wdata_reg;
        unique case (ph_reg)
            ABD_PH_DECODE: begin
                // a taken branch spends one whole cycle as a no-op
                live_next = instr_valid && !flush_reg;
                if (instr_valid) begin
                    ir_next = instr_word;
                    pc_next = pc_reg + PC_STEP;
                end
                ph_next = ABD_PH_READ;
            end
            ABD_PH_READ: begin
                // access bit clear forces the access bank
                if (is_regop) begin
                    addr_next = {ir_reg[8] ? bank_select_register
                                           : ACCESS_BANK, ir_reg[7:0]};
                end
                opnd_next = ir_reg[7:0];
                ph_next   = ABD_PH_PROCESS;
            end
            ABD_PH_PROCESS: begin
                // file data is valid one phase after the address
                stres_next = stat_reg;
                res_next   = opnd_reg;
                if (is_addimm) begin
                    res_next   = add9(work_reg, opnd_reg, 1'b0)
                                 [7:0];
                    stres_next = add_flags(work_reg, opnd_reg, 1'b0);
                end else if (is_add || is_addc) begin
                    res_next   = add9(work_reg, file_rdata,
                                      is_addc & stat_reg[FLAG_C])
                                 [7:0];
                    stres_next = add_flags(work_reg, file_rdata,
                                 is_addc & stat_reg[FLAG_C]);
                end else if (is_andimm || is_and) begin
                    res_next = work_reg &
                               (is_andimm ? opnd_reg : file_rdata);
                    stres_next[FLAG_Z] = (res_next == 8'h00);
                    stres_next[FLAG_N] = res_next[7];
                end else if (is_bclr) begin
                    res_next = file_rdata &
                               ~(8'h01 << ir_reg[11:9]);
                end
                ph_next = ABD_PH_WRITE;
            end
            ABD_PH_WRITE: begin
                flush_next = 1'b0;
                if (live_reg) begin
                    if (is_addimm || is_andimm) begin
                        work_next = res_reg;
                        stat_next = stres_reg;
                    end else if (is_add || is_addc || is_and) begin
                        stat_next = stres_reg;
                        if (ir_reg[9]) begin
                            we_next    = 1'b1;
                            wdata_next = res_reg;
                        end else begin
                            work_next = res_reg;
                        end
                    end else if (is_bclr) begin
                        we_next    = 1'b1;
                        wdata_next = res_reg;
                    end else if (is_branch && br_cond) begin
                        pc_next    = br_target;
                        flush_next = 1'b1;
                    end
                end
                ph_next = ABD_PH_DECODE;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            ph_reg    <= ABD_PH_DECODE;
            ir_reg    <= 16'h0000;
            live_reg  <= 1'b0;
            flush_reg <= 1'b0;
            opnd_reg  <= 8'h00;
            res_reg   <= 8'h00;
            stres_reg <= STATUS_RST;
            work_reg  <= WORK_RST;
            stat_reg  <= STATUS_RST;
            pc_reg    <= PC_RST;
            addr_reg  <= 12'h000;
            we_reg    <= 1'b0;
            wdata_reg <= 8'h00;
        end else begin
            ph_reg    <= ph_next;
            ir_reg    <= ir_next;
            live_reg  <= live_next;
            flush_reg <= flush_next;
            opnd_reg  <= opnd_next;
            res_reg   <= res_next;
            stres_reg <= stres_next;
            work_reg  <= work_next;
            stat_reg  <= stat_next;
            pc_reg    <= pc_next;
            addr_reg  <= addr_next;
            we_reg    <= we_next;
            wdata_reg <= wdata_next;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign file_addr    = addr_reg;
    assign file_we      = we_reg;
    assign file_wdata   = wdata_reg;
    assign work_value   = work_reg;
    assign status_flags = stat_reg;
    assign pc_value     = pc_reg;
    assign phase        = ph_reg;
    assign instr_accept = (ph_reg == ABD_PH_DECODE);
    assign flush_busy   = flush_reg;
endmodule : abd_core
`default_nettype wire

// File: abd_core_checker.sv
// assertion checker for the alu and branch decode slice
`timescale 1ns/1ps
`default_nettype none
module abd_core_checker
    import abd_pkg::*;
(
    input wire logic        clk_sys,
    input wire logic        resetn,
    input wire logic [15:0] instr_word,
    input wire logic        instr_valid,
    input wire logic [3:0]  bank_select_register,
    input wire logic [7:0]  file_rdata,
    input wire logic [11:0] file_addr,
    input wire logic        file_we,
    input wire logic [7:0]  file_wdata,
    input wire logic [7:0]  work_value,
    input wire logic [4:0]  status_flags,
    input wire logic [20:0] pc_value,
    input wire logic [3:0]  phase,
    input wire logic        instr_accept,
    input wire logic        flush_busy
);
    // ------------------------------------------------------------
    // decoded takes; a flushed slot never counts as a take
    // ------------------------------------------------------------
    wire logic       tk  = instr_accept & instr_valid & ~flush_busy;
    wire logic [3:0] hi  = instr_word[15:12];
    wire logic [3:0] sub = instr_word[11:8];
    wire logic       bro = tk & (hi == OP_BRANCH_HI);
    wire logic       bco = tk & (hi == OP_BITCLR_HI);
    wire logic       ado = tk & (hi == OP_ADDREG_HI) & ~instr_word[11];
    wire logic       ano = tk & (hi == OP_ANDREG_HI)
                           & (sub[3:2] == OP_AND_REG);
    wire logic       adi = tk & (hi == OP_LIT_HI) & (sub == OP_ADD_IMM);
    wire logic       ali = tk & (hi == OP_LIT_HI) & (sub == OP_AND_IMM);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    AST_ACCEPT: assert property (
        instr_accept == (phase == ABD_PH_DECODE))
        else $error("accept not tied to decode phase");
    AST_PHASE: assert property (phase == ABD_PH_DECODE |=>
        phase == ABD_PH_READ ##1 phase == ABD_PH_PROCESS
        ##1 phase == ABD_PH_WRITE) else $error("phase order broken");
    AST_HOLD: assert property (phase != ABD_PH_WRITE |=>
        $stable(status_flags) && $stable(work_value))
        else $error("state changed outside write phase");
    AST_PC: assert property (
        tk |=> pc_value == $past(pc_value) + PC_STEP)
        else $error("pc not stepped on take");
    AST_ADDI: assert property (adi |-> ##4 work_value ==
        8'($past(work_value, 4) + $past(instr_word[7:0], 4))
        && status_flags[FLAG_Z] == (work_value == 8'h00))
        else $error("add immediate result wrong");
    AST_BRKEEP: assert property (bro |-> ##4
        status_flags == $past(status_flags, 4)
        && work_value == $past(work_value, 4))
        else $error("branch touched flags or work");
    AST_BITCLR: assert property (bco |-> ##4 file_we
        && file_wdata[$past(instr_word[11:9], 4)] == 1'b0
        && status_flags == $past(status_flags, 4))
        else $error("bit clear wrong");
    AST_DEST: assert property ((ado | ano) |-> ##4
        file_we == $past(instr_word[9], 4)) else $error("destination wrong");
    AST_BANK: assert property ((ado | ano | bco) |-> ##4 file_addr ==
        {($past(instr_word[8], 4) ? $past(bank_select_register, 3)
        : ACCESS_BANK), $past(instr_word[7:0], 4)})
        else $error("file address or bank wrong");
    AST_ANDFLAGS: assert property ((ano | ali) |-> ##4
        (status_flags & 5'h0B) == ($past(status_flags, 4) & 5'h0B))
        else $error("and changed carry or overflow");
endmodule : abd_core_checker
bind abd_core abd_core_checker abd_core_checker_inst (
    .clk_sys(clk_sys), .resetn(resetn), .instr_word(instr_word),
    .instr_valid(instr_valid), .bank_select_register(bank_select_register),
    .file_rdata(file_rdata), .file_addr(file_addr), .file_we(file_we),
    .file_wdata(file_wdata), .work_value(work_value),
    .status_flags(status_flags), .pc_value(pc_value), .phase(phase),
    .instr_accept(instr_accept), .flush_busy(flush_busy));
`default_nettype wire

// File: abd_core_tb.sv
// self-checking testbench for the alu and branch decode slice
`timescale 1ns/1ps
`default_nettype none
module abd_core_tb
    import abd_pkg::*;
;
    logic        clk_sys;
    logic        resetn;
    logic [15:0] instr_word;
    logic        instr_valid;
    logic [3:0]  bank_select_register;
    logic [7:0]  file_rdata;
    logic [11:0] file_addr;
    logic        file_we;
    logic [7:0]  file_wdata;
    logic [7:0]  work_value;
    logic [4:0]  status_flags;
    logic [20:0] pc_value;
    logic [3:0]  phase;
    logic        instr_accept;
    logic        flush_busy;
    logic [20:0] exp_pc;
    logic [15:0] next_word;
    logic        hold_next;
    int          fails;
    int          n_tests;
    abd_core abd_core_inst (
        .clk_sys(clk_sys), .resetn(resetn), .instr_word(instr_word),
        .instr_valid(instr_valid), .bank_select_register(bank_select_register),
        .file_rdata(file_rdata), .file_addr(file_addr), .file_we(file_we),
        .file_wdata(file_wdata), .work_value(work_value),
        .status_flags(status_flags), .pc_value(pc_value), .phase(phase),
        .instr_accept(instr_accept), .flush_busy(flush_busy));
    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic chk(input string what, input logic [20:0] seen,
                       input logic [20:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic final_report;
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : final_report
    task automatic rst;
        @(posedge clk_sys);
        resetn <= 1'b0;
        repeat (2) @(posedge clk_sys);
        resetn <= 1'b1;
        exp_pc = '0;
    endtask : rst
    // waits for a decode slot, then returns just after the update edge
    task automatic exe(input logic [15:0] w, input logic [7:0] rd,
                       input logic [3:0] bk);
        int n;
        n = 0;
        do begin
            @(posedge clk_sys);
            instr_word <= w;
            instr_valid <= 1'b1;
            file_rdata <= rd;
            bank_select_register <= bk;
            #1;
            n++;
        end while (instr_accept !== 1'b1 && n < 8);
        @(posedge clk_sys);
        // hold_next puts a word in the very next decode slot
        if (hold_next)
            instr_word <= next_word;
        else
            instr_valid <= 1'b0;
        repeat (3) @(posedge clk_sys);
        #1;
        exp_pc = exp_pc + PC_STEP;
    endtask : exe
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_arith;
        exe({OP_LIT_HI, OP_ADD_IMM, 8'h15}, 8'h00, 4'h0);
        chk("work", work_value, 8'h15);
        exe({OP_LIT_HI, OP_ADD_IMM, 8'hEB}, 8'h00, 4'h0);
        chk("flags", {work_value, status_flags}, 13'h0007);
        exe({OP_LIT_HI, OP_ADD_IMM, 8'h80}, 8'h00, 4'h0);
        exe({OP_ADDREG_HI, OP_ADD_REG, 2'b11, 8'h34}, 8'h80, 4'h5);
        chk("flags", {work_value, status_flags}, 13'h100D);
        chk("wr", {file_we, file_addr, file_wdata}, 21'h153400);
        exe({OP_ADDREG_HI, OP_ADDC_REG, 2'b00, 8'h34}, 8'h80, 4'h5);
        chk("flags", {work_value, status_flags}, 13'h0029);
        chk("wr", {file_we, file_addr}, 13'h0034);
        exe({OP_LIT_HI, OP_AND_IMM, 8'h81}, 8'h00, 4'h0);
        chk("flags", {work_value, status_flags}, 13'h0029);
        exe({OP_ANDREG_HI, OP_AND_REG, 2'b10, 8'h10}, 8'h00, 4'h2);
        chk("flags", {work_value, status_flags}, 13'h002D);
        chk("wr", {file_we, file_addr, file_wdata}, 21'h101000);
        exe({OP_BITCLR_HI, 3'd7, 1'b1, 8'h12}, 8'hC7, 4'h3);
        chk("flags", {work_value, status_flags}, 13'h002D);
        chk("wr", {file_we, file_addr, file_wdata}, 21'h131247);
        chk("pc", pc_value, exp_pc);
        $display("test arith done");
    endtask : t_arith
    task automatic t_branch;
        logic [3:0] code [6] = '{BR_CARRY, BR_NO_CARRY, BR_NEGATIVE,
                                 BR_NOT_NEG, BR_NO_OVFL, BR_NOT_ZERO};
        int         idx [6]  = '{FLAG_C, FLAG_C, FLAG_N, FLAG_N, FLAG_OV,
                                 FLAG_Z};
        logic       pol [6]  = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0};
        logic [4:0] fl [3]   = '{5'h00, 5'h10, 5'h0D};
        logic [7:0] wk [3]   = '{8'h00, 8'h80, 8'h00};
        logic [7:0] off;
        logic       take;
        for (int s = 0; s < 3; s++) begin
            for (int i = 0; i < 6; i++) begin
                rst();
                for (int k = 0; k < s; k++)
                    exe({OP_LIT_HI, OP_ADD_IMM, 8'h80}, 8'h00, 4'h0);
                off = i[0] ? 8'h80 : 8'h7F;
                take = (fl[s][idx[i]] == pol[i]);
                next_word = {OP_LIT_HI, OP_ADD_IMM, 8'h01};
                hold_next = take;
                exe({OP_BRANCH_HI, code[i], off}, 8'h00, 4'h0);
                hold_next = 1'b0;
                if (take) exp_pc = exp_pc + {{12{off[7]}}, off, 1'b0};
                chk("pc", pc_value, exp_pc);
                chk("flags", status_flags, fl[s]);
                chk("flush", flush_busy, take);
                if (take) begin
                    // the word in the flushed slot must leave work untouched; pc still steps by PC_STEP
                    @(posedge clk_sys);
                    instr_valid <= 1'b0;
                    repeat (3) @(posedge clk_sys);
                    #1;
                    exp_pc = exp_pc + PC_STEP;
                    chk("work", work_value, wk[s]);
                    chk("pc", pc_value, exp_pc);
                end
            end
        end
        $display("test branch done");
    endtask : t_branch
    // ------------------------------------------------------------
    // clock, watchdog, main sequence
    // ------------------------------------------------------------
    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end
    initial begin
        #500000;
        fails++;
        final_report();
    end
    initial begin
        resetn = 1'b0;
        instr_word = '0;
        instr_valid = 1'b0;
        bank_select_register = '0;
        file_rdata = '0;
        exp_pc = '0;
        next_word = '0;
        hold_next = 1'b0;
        fails = 0;
        n_tests = 0;
        repeat (16) @(posedge clk_sys);
        resetn <= 1'b1;
        t_arith();
        t_branch();
        final_report();
    end
endmodule : abd_core_tb
`default_nettype wire
